// File: rtl/flash_seq_pkg.sv
/*
  Constants shared by the flash sequencer command and status logic.
  Assumes a byte-wide CPU data port with a 20-bit address space.
*/
package flash_seq_pkg;

  localparam int CPU_AW   = 20;
  localparam int FLASH_AW = 13;

  // Register addresses on the CPU data port.
  localparam logic [19:0] SEQUENCER_COMMAND_ADDR      = 20'hF00C1;
  localparam logic [19:0] SEQUENCER_ERROR_STATUS_ADDR = 20'hF00C6;
  localparam logic [19:0] SEQUENCER_END_STATUS_ADDR   = 20'hF00C7;

  // Reset values.
  localparam logic [7:0] SEQUENCER_COMMAND_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET            = 8'h00;

  // Field positions.
  localparam int RUN_CONTROL_BIT    = 7;
  localparam int COMMAND_SELECT_MSB = 2;
  localparam int END_FLAG_BIT       = 6;
  localparam int GENERAL_ERROR_BIT  = 4;
  localparam int WRITE_ERROR_BIT    = 1;
  localparam int ERASE_ERROR_BIT    = 0;

  // Command codes.
  localparam logic [2:0] CMD_NONE  = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h4;

  // Flash array operation codes.
  localparam logic FLASH_OP_WRITE = 1'h0;
  localparam logic FLASH_OP_ERASE = 1'h1;

  // Block sizes as address shifts: 1 Kbyte code, 512 bytes data.
  localparam int CODE_BLOCK_SHIFT = 10;
  localparam int DATA_BLOCK_SHIFT = 9;
  // One write word is 4 bytes.
  localparam int WORD_SHIFT = 2;

endpackage

// File: rtl/seq_ctl_if.sv
/*
  Carrier between the register side and the operation engine.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ns
interface seq_ctl_if;
  logic                                start;
  logic                                abort;
  logic [2:0]                          cmd;
  logic                                area;
  logic [flash_seq_pkg::FLASH_AW-1:0]  start_addr;
  logic [flash_seq_pkg::FLASH_AW-1:0]  end_addr;
  logic [31:0]                         wdata;
  logic                                done;
  logic                                gen_err;
  logic                                wr_err;
  logic                                er_err;

  modport ctrl (
    output start, abort, cmd, area, start_addr, end_addr, wdata,
    input  done, gen_err, wr_err, er_err
  );
  modport engine (
    input  start, abort, cmd, area, start_addr, end_addr, wdata,
    output done, gen_err, wr_err, er_err
  );
endinterface

// File: rtl/seq_engine.sv
/*
  Operation engine: runs one write or a range of block erases on the
  flash array. Assumes the array answers each request with a one-cycle
  acknowledge on core_clk, carrying a fail level in the same cycle.
*/
`timescale 1ns/1ns
module seq_engine (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // Control carrier
  seq_ctl_if.engine                                ctl,
  // Flash array port
  output logic                                     flash_req,
  output logic                                     flash_op,
  output logic [flash_seq_pkg::FLASH_AW-1:0]       flash_addr,
  output logic [31:0]                              flash_wdata,
  input  wire logic                                flash_ack,
  input  wire logic                                flash_fail
);

  localparam int FLASH_AW_T = flash_seq_pkg::FLASH_AW;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_FINISH} state_t;

  state_t                              state;
  logic   [flash_seq_pkg::FLASH_AW-1:0] cur;
  logic   [flash_seq_pkg::FLASH_AW-1:0] last;
  logic                                 area;
  logic                                 op;

  // Block number of an address for the selected area.
  function automatic logic [flash_seq_pkg::FLASH_AW-1:0] block_of(
    input logic [flash_seq_pkg::FLASH_AW-1:0] a,
    input logic                               data_area);
    block_of = data_area ? (a >> flash_seq_pkg::DATA_BLOCK_SHIFT)
                         : (a >> flash_seq_pkg::CODE_BLOCK_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencing.
  always_ff @(posedge core_clk) begin
    flash_req   <= 1'b0;
    ctl.done    <= 1'b0;
    if (rst) begin
      state       <= S_IDLE;
      cur         <= '0;
      last        <= '0;
      area        <= 1'b0;
      op          <= flash_seq_pkg::FLASH_OP_WRITE;
      flash_op    <= flash_seq_pkg::FLASH_OP_WRITE;
      flash_addr  <= '0;
      flash_wdata <= '0;
      ctl.gen_err <= 1'b0;
      ctl.wr_err  <= 1'b0;
      ctl.er_err  <= 1'b0;
    end else if (ctl.abort) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (ctl.start) begin
            ctl.gen_err <= 1'b0;
            ctl.wr_err  <= 1'b0;
            ctl.er_err  <= 1'b0;
            area        <= ctl.area;
            last        <= ctl.end_addr;
            flash_wdata <= ctl.wdata;
            if (ctl.cmd == flash_seq_pkg::CMD_WRITE) begin
              op    <= flash_seq_pkg::FLASH_OP_WRITE;
              // A write is always one aligned 4-byte word.
              cur   <= (ctl.start_addr >> flash_seq_pkg::WORD_SHIFT)
                       << flash_seq_pkg::WORD_SHIFT;
              state <= S_ISSUE;
            end else if (ctl.cmd == flash_seq_pkg::CMD_ERASE) begin
              op  <= flash_seq_pkg::FLASH_OP_ERASE;
              cur <= ctl.area
                ? (block_of(ctl.start_addr, 1'b1)
                   << flash_seq_pkg::DATA_BLOCK_SHIFT)
                : (block_of(ctl.start_addr, 1'b0)
                   << flash_seq_pkg::CODE_BLOCK_SHIFT);
              if (block_of(ctl.start_addr, ctl.area) >
                  block_of(ctl.end_addr, ctl.area)) begin
                ctl.er_err  <= 1'b1;
                ctl.gen_err <= 1'b1;
                state       <= S_FINISH;
              end else begin
                state <= S_ISSUE;
              end
            end else begin
              // No command or a prohibited code is a sequencer error.
              ctl.gen_err <= 1'b1;
              state       <= S_FINISH;
            end
          end
        end
        S_ISSUE: begin
          flash_req  <= 1'b1;
          flash_op   <= op;
          flash_addr <= cur;
          state      <= S_WAIT;
        end
        S_WAIT: begin
          if (flash_ack) begin
            if (flash_fail) begin
              ctl.gen_err <= 1'b1;
              if (op == flash_seq_pkg::FLASH_OP_WRITE) begin
                ctl.wr_err <= 1'b1;
              end else begin
                ctl.er_err <= 1'b1;
              end
              state <= S_FINISH;
            end else if (op == flash_seq_pkg::FLASH_OP_ERASE &&
                         block_of(cur, area) < block_of(last, area)) begin
              cur   <= area
                ? FLASH_AW_T'(cur + (1 << flash_seq_pkg::DATA_BLOCK_SHIFT))
                : FLASH_AW_T'(cur + (1 << flash_seq_pkg::CODE_BLOCK_SHIFT));
              state <= S_ISSUE;
            end else begin
              state <= S_FINISH;
            end
          end
        end
        S_FINISH: begin
          ctl.done <= 1'b1;
          state    <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// File: rtl/flash_sequencer_cmd_status.sv
/*
  Command and status registers of the flash sequencer, with the CPU
  wait and the engine that drives the flash array.
  Assumes a byte-wide CPU data port with one-cycle write and read
  strobes on core_clk, and a flash array on the same clock.
*/
// Summary of operation
// - Run bit set starts, cleared stops.
// - Command field selects; zero means none.
// - Code 001b writes buffer word to pointer.
// - Each write programs one 4-byte word.
// - Code 100b erases start through end block.
// - Code area erases 1 Kbyte blocks.
// - Data area erases 512-byte blocks.
// - End flag low busy, high ended.
// - End flag clears when run bit cleared.
// - General error set on error, cleared on start.
// - Write error set on failure, cleared on start.
// - Erase error set on failure, cleared on start.
// - Command register byte-writable, resets to zero.
// - Status registers read-only, zero unused bits.
// - Area bit picks code or data flash; only sets erase block size, not sent to array.
// - Start holds CPU in wait until finished.
`timescale 1ns/1ns
module flash_sequencer_cmd_status (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  // CPU data port
  input  wire logic [flash_seq_pkg::CPU_AW-1:0]    mem_addr,
  input  wire logic                                mem_we,
  input  wire logic                                mem_re,
  input  wire logic [7:0]                          mem_wdata,
  output logic      [7:0]                          mem_rdata,
  // CPU wait
  output logic                                     cpu_wait,
  // Settings held by neighbouring registers
  input  wire logic                                area_select_bit,
  input  wire logic [flash_seq_pkg::FLASH_AW-1:0]  address_pointer,
  input  wire logic [flash_seq_pkg::FLASH_AW-1:0]  erase_end_address,
  input  wire logic [31:0]                         write_buffer,
  // Flash array port
  output logic                                     flash_req,
  output logic                                     flash_op,
  output logic      [flash_seq_pkg::FLASH_AW-1:0]  flash_addr,
  output logic      [31:0]                         flash_wdata,
  input  wire logic                                flash_ack,
  input  wire logic                                flash_fail
);

  seq_ctl_if ctl ();

  logic       run_control_bit;
  logic [2:0] command_select_field;
  logic       end_flag;
  logic       general_error_flag;
  logic       write_error_flag;
  logic       erase_error_flag;
  logic       cmd_write;
  logic       activate;
  logic       stop;

  assign cmd_write = mem_we &&
                     mem_addr == flash_seq_pkg::SEQUENCER_COMMAND_ADDR;
  assign activate  = cmd_write &&
                     mem_wdata[flash_seq_pkg::RUN_CONTROL_BIT] &&
                     !run_control_bit;
  assign stop      = cmd_write &&
                     !mem_wdata[flash_seq_pkg::RUN_CONTROL_BIT] &&
                     run_control_bit;

  ////////////////////////////////////////////////////////////////////////
  // Command register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_control_bit      <= flash_seq_pkg::SEQUENCER_COMMAND_RESET
                              [flash_seq_pkg::RUN_CONTROL_BIT];
      command_select_field <= flash_seq_pkg::SEQUENCER_COMMAND_RESET
                              [flash_seq_pkg::COMMAND_SELECT_MSB:0];
    end else if (cmd_write) begin
      run_control_bit      <= mem_wdata[flash_seq_pkg::RUN_CONTROL_BIT];
      command_select_field <=
        mem_wdata[flash_seq_pkg::COMMAND_SELECT_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start and stop pulses to the engine, with settings captured.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl.start      <= 1'b0;
      ctl.abort      <= 1'b0;
      ctl.cmd        <= flash_seq_pkg::CMD_NONE;
      ctl.area       <= 1'b0;
      ctl.start_addr <= '0;
      ctl.end_addr   <= '0;
      ctl.wdata      <= '0;
    end else begin
      ctl.start <= activate;
      ctl.abort <= stop;
      if (activate) begin
        ctl.cmd        <= mem_wdata[flash_seq_pkg::COMMAND_SELECT_MSB:0];
        ctl.area       <= area_select_bit;
        ctl.start_addr <= address_pointer;
        ctl.end_addr   <= erase_end_address;
        ctl.wdata      <= write_buffer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU wait: held from start until the operation ends or is stopped.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_wait <= 1'b0;
    end else if (activate) begin
      cpu_wait <= 1'b1;
    end else if (ctl.done || ctl.abort) begin
      cpu_wait <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // End flag: set by the engine, cleared by the run bit going low.
  // The set wins when both happen in one cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      end_flag <= 1'b0;
    end else if (ctl.done && run_control_bit) begin
      end_flag <= 1'b1;
    end else if (stop || activate) begin
      end_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags: cleared at activation, loaded with the end pulse.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      general_error_flag <= 1'b0;
      write_error_flag   <= 1'b0;
      erase_error_flag   <= 1'b0;
    end else if (ctl.done) begin
      general_error_flag <= ctl.gen_err;
      write_error_flag   <= ctl.wr_err;
      erase_error_flag   <= ctl.er_err;
    end else if (activate) begin
      general_error_flag <= 1'b0;
      write_error_flag   <= 1'b0;
      erase_error_flag   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port. Status registers ignore writes; unmapped reads give zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_rdata <= flash_seq_pkg::STATUS_RESET;
    end else if (mem_re) begin
      mem_rdata <= flash_seq_pkg::STATUS_RESET;
      case (mem_addr)
        flash_seq_pkg::SEQUENCER_COMMAND_ADDR: begin
          mem_rdata[flash_seq_pkg::RUN_CONTROL_BIT] <= run_control_bit;
          mem_rdata[flash_seq_pkg::COMMAND_SELECT_MSB:0] <=
            command_select_field;
        end
        flash_seq_pkg::SEQUENCER_ERROR_STATUS_ADDR: begin
          mem_rdata[flash_seq_pkg::GENERAL_ERROR_BIT] <=
            general_error_flag;
          mem_rdata[flash_seq_pkg::WRITE_ERROR_BIT] <= write_error_flag;
          mem_rdata[flash_seq_pkg::ERASE_ERROR_BIT] <= erase_error_flag;
        end
        flash_seq_pkg::SEQUENCER_END_STATUS_ADDR: begin
          mem_rdata[flash_seq_pkg::END_FLAG_BIT] <= end_flag;
        end
        default: begin
          mem_rdata <= flash_seq_pkg::STATUS_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation engine.
  seq_engine engine (
    .core_clk    (core_clk),
    .rst         (rst),
    .ctl         (ctl),
    .flash_req   (flash_req),
    .flash_op    (flash_op),
    .flash_addr  (flash_addr),
    .flash_wdata (flash_wdata),
    .flash_ack   (flash_ack),
    .flash_fail  (flash_fail)
  );

endmodule

// File: testbench/seq_monitor.sv
/*
  Port checker for the flash sequencer command and status block.
  Assumes it is bound to every instance of that block.
*/
`timescale 1ns/1ns
module seq_monitor (
  // Clock and reset
  input wire logic                               core_clk,
  input wire logic                               rst,
  // CPU side
  input wire logic [flash_seq_pkg::CPU_AW-1:0]   mem_addr,
  input wire logic                               mem_we,
  input wire logic                               mem_re,
  input wire logic [7:0]                         mem_wdata,
  input wire logic [7:0]                         mem_rdata,
  input wire logic                               cpu_wait,
  input wire logic                               area_select_bit,
  input wire logic [31:0]                        write_buffer,
  // Flash array side
  input wire logic                               flash_req,
  input wire logic                               flash_op,
  input wire logic [flash_seq_pkg::FLASH_AW-1:0] flash_addr,
  input wire logic [31:0]                        flash_wdata,
  input wire logic                               flash_ack
);
  logic run_q;
  logic cmd_wr;
  logic good_cmd;
  assign cmd_wr = mem_we && mem_addr == flash_seq_pkg::SEQUENCER_COMMAND_ADDR;
  assign good_cmd = mem_wdata[2:0] == flash_seq_pkg::CMD_WRITE
                 || mem_wdata[2:0] == flash_seq_pkg::CMD_ERASE;
  // Mirror of the run bit, so a rewrite of 1 is not taken as a start.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (cmd_wr) begin
      run_q <= mem_wdata[7];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  start_waits_a: assert property (cmd_wr && mem_wdata[7] && !run_q
    && good_cmd |=> cpu_wait) else $error("no cpu wait after start");
  stop_frees_a: assert property (cmd_wr && !mem_wdata[7]
    |-> ##2 !cpu_wait) else $error("cpu wait kept after stop");
  req_in_wait_a: assert property (flash_req |-> cpu_wait)
    else $error("array request outside cpu wait");
  req_pulse_a: assert property (flash_req |=> !flash_req)
    else $error("array request longer than one cycle");
  ack_gap_a: assert property (flash_ack |=> !flash_req)
    else $error("request too soon after acknowledge");
  word_write_a: assert property (flash_req && !flash_op
    |-> flash_addr[1:0] == 2'h0 && flash_wdata == write_buffer)
    else $error("write word misplaced or wrong");
  code_block_a: assert property (flash_req && flash_op
    && !area_select_bit |-> flash_addr[9:0] == 10'h000)
    else $error("code erase not on a 1 Kbyte block");
  data_block_a: assert property (flash_req && flash_op
    && area_select_bit |-> flash_addr[8:0] == 9'h000)
    else $error("data erase not on a 512 byte block");
  end_bits_a: assert property (mem_re && mem_addr
    == flash_seq_pkg::SEQUENCER_END_STATUS_ADDR |=> !(mem_rdata & 8'hBF))
    else $error("end status unused bit set");
  err_bits_a: assert property (mem_re && mem_addr
    == flash_seq_pkg::SEQUENCER_ERROR_STATUS_ADDR |=> !(mem_rdata & 8'hEC))
    else $error("error status unused bit set");
endmodule
bind flash_sequencer_cmd_status seq_monitor u_mon (.core_clk, .rst,
  .mem_addr, .mem_we, .mem_re, .mem_wdata, .mem_rdata, .cpu_wait,
  .area_select_bit, .write_buffer, .flash_req, .flash_op, .flash_addr,
  .flash_wdata, .flash_ack);

// File: testbench/tb.sv
/*
  Self-checking bench for the flash sequencer command and status block.
  Assumes the bench itself plays the CPU and the flash array.
*/
`timescale 1ns/1ns
module tb;
  localparam logic [19:0] CMD = flash_seq_pkg::SEQUENCER_COMMAND_ADDR;
  localparam logic [19:0] ERR = flash_seq_pkg::SEQUENCER_ERROR_STATUS_ADDR;
  localparam logic [19:0] ENDS = flash_seq_pkg::SEQUENCER_END_STATUS_ADDR;
  logic                                core_clk;
  logic                                rst;
  logic [flash_seq_pkg::CPU_AW-1:0]    mem_addr;
  logic                                mem_we;
  logic                                mem_re;
  logic [7:0]                          mem_wdata;
  logic [7:0]                          mem_rdata;
  logic                                cpu_wait;
  logic                                area_select_bit;
  logic [flash_seq_pkg::FLASH_AW-1:0]  address_pointer;
  logic [flash_seq_pkg::FLASH_AW-1:0]  erase_end_address;
  logic [31:0]                         write_buffer;
  logic                                flash_req;
  logic                                flash_op;
  logic [flash_seq_pkg::FLASH_AW-1:0]  flash_addr;
  logic [31:0]                         flash_wdata;
  logic                                flash_ack;
  logic                                flash_fail;
  logic                                fail_mode;
  logic [12:0]                         req_addr [0:15];
  logic                                req_op [0:15];
  logic [7:0]                          d;
  int                                  fails;
  int                                  n_tests;
  int                                  cycles;
  int                                  n_req;
  int                                  ack_cnt;
  int                                  ack_delay;
  flash_sequencer_cmd_status u_dut (.core_clk, .rst, .mem_addr, .mem_we,
    .mem_re, .mem_wdata, .mem_rdata, .cpu_wait, .area_select_bit,
    .address_pointer, .erase_end_address, .write_buffer, .flash_req,
    .flash_op, .flash_addr, .flash_wdata, .flash_ack, .flash_fail);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Flash array stand-in: records requests, answers after ack_delay cycles.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    flash_ack <= 1'b0;
    flash_fail <= 1'b0;
    if (ack_cnt == 1) begin
      flash_ack <= 1'b1;
      flash_fail <= fail_mode;
    end
    if (ack_cnt > 0) ack_cnt <= ack_cnt - 1;
    if (flash_req) begin
      req_addr[n_req[3:0]] <= flash_addr;
      req_op[n_req[3:0]] <= flash_op;
      n_req <= n_req + 1;
      ack_cnt <= ack_delay;
    end
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] v);
    @(posedge core_clk);
    mem_we <= 1'b1;
    mem_addr <= a;
    mem_wdata <= v;
    @(posedge core_clk);
    mem_we <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, output logic [7:0] v);
    @(posedge core_clk);
    mem_re <= 1'b1;
    mem_addr <= a;
    @(posedge core_clk);
    mem_re <= 1'b0;
    #1 v = mem_rdata;
  endtask
  task automatic run(input logic [7:0] cmd, input logic area,
      input logic [12:0] ptr, input logic [12:0] last, input logic fl,
      input int nexp, input logic [12:0] base, input logic [12:0] step,
      input logic [7:0] err);
    int i;
    @(posedge core_clk);
    area_select_bit <= area;
    address_pointer <= ptr;
    erase_end_address <= last;
    fail_mode <= fl;
    n_req = 0;
    wr(CMD, cmd);
    i = 0;
    repeat (2) @(posedge core_clk);
    while (cpu_wait !== 1'b0 && i < 300) begin
      @(posedge core_clk);
      i++;
    end
    check(n_req, nexp);
    for (i = 0; i < nexp; i++) begin
      check(req_addr[i], base + step * 13'(i));
      check(req_op[i], cmd[2:0] == flash_seq_pkg::CMD_ERASE);
    end
    rd(ENDS, d);
    check(d, 8'h40);
    rd(ERR, d);
    check(d, err);
    rd(CMD, d);
    check(d, cmd & 8'h87);
    wr(CMD, 8'h00);
    rd(ENDS, d);
    check(d, 8'h00);
    rd(ERR, d);
    check(d, err);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(CMD, d);
    check(d, 8'h00);
    rd(ERR, d);
    check(d, 8'h00);
    wr(ERR, 8'hFF);
    wr(ENDS, 8'hFF);
    rd(ERR, d);
    check(d, 8'h00);
    rd(ENDS, d);
    check(d, 8'h00);
    rd(20'hF00C2, d);
    check(d, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_write();
    run(8'h81, 1'b0, 13'h0123, 13'h0000, 1'b0, 1, 13'h0120, 0, 8'h00);
    run(8'h81, 1'b1, 13'h0207, 13'h0000, 1'b0, 1, 13'h0204, 0, 8'h00);
    $display("test write done");
  endtask
  task automatic t_erase();
    ack_delay = 12;
    run(8'h84, 1'b0, 13'h0400, 13'h0BFC, 1'b0, 2, 13'h0400, 13'h0400,
        8'h00);
    run(8'h84, 1'b1, 13'h0000, 13'h03FC, 1'b0, 2, 13'h0000, 13'h0200,
        8'h00);
    run(8'h84, 1'b0, 13'h0800, 13'h0400, 1'b0, 0, 0, 0, 8'h11);
    ack_delay = 3;
    $display("test erase done");
  endtask
  task automatic t_fail();
    run(8'h81, 1'b0, 13'h0010, 13'h0000, 1'b1, 1, 13'h0010, 0, 8'h12);
    run(8'h84, 1'b1, 13'h0000, 13'h01FC, 1'b1, 1, 0, 0, 8'h11);
    run(8'h81, 1'b0, 13'h0010, 13'h0000, 1'b0, 1, 13'h0010, 0, 8'h00);
    $display("test fail done");
  endtask
  task automatic t_badcmd();
    logic [2:0] c;
    foreach (req_op[k]) begin
      c = 3'(k);
      if (k < 8 && c != 3'h1 && c != 3'h4) begin
        run({5'h10, c}, 1'b0, 0, 0, 1'b0, 0, 0, 0, 8'h10);
      end
    end
    $display("test badcmd done");
  endtask
  task automatic t_abort();
    ack_delay = 40;
    @(posedge core_clk);
    address_pointer <= 13'h0000;
    erase_end_address <= 13'h07FC;
    area_select_bit <= 1'b0;
    wr(CMD, 8'h84);
    repeat (5) @(posedge core_clk);
    check(cpu_wait, 1'b1);
    rd(ENDS, d);
    check(d, 8'h00);
    wr(CMD, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 check(cpu_wait, 1'b0);
    rd(ENDS, d);
    check(d, 8'h00);
    rd(ERR, d);
    check(d, 8'h00);
    repeat (50) @(posedge core_clk);
    ack_delay = 3;
    $display("test abort done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    fails = 0;
    n_tests = 0;
    cycles = 0;
    n_req = 0;
    ack_cnt = 0;
    ack_delay = 3;
    fail_mode = 1'b0;
    rst = 1'b1;
    mem_addr = '0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_wdata = 8'h00;
    area_select_bit = 1'b0;
    address_pointer = '0;
    erase_end_address = '0;
    write_buffer = 32'hA5C30F96;
    flash_ack = 1'b0;
    flash_fail = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_write();
    t_erase();
    t_fail();
    t_badcmd();
    t_abort();
    wrap_up();
  end
endmodule
